// file: core/indirect_load_pkg.sv
// constants for the indirect load execution block
// Operation
// (RL1) indirect load copies addressed byte into working register
// (RL2) mode field: pre-inc, pre-dec, post-inc, post-dec
// (RL3) address and pointer writeback follow the mode
// (RL4) virtual indirect regs redirect to pointer address
// (RL5) any instruction on virtual reg uses pointer
// (RL6) pointers stay within 0000h to FFFFh, wrapping
// (RL7) zero flag tracks loaded byte, others unchanged
package indirect_load_pkg;
  localparam int PTR_W  = 16;
  localparam int DATA_W = 8;
  localparam int OFS_W  = 6;
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;
  localparam logic [PTR_W-1:0]  PTR_RESET  = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_ONE    = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } exec_state_t;
endpackage

// file: core/indirect_load_addressing.sv
// execution logic for the indirect load instruction
`timescale 1ns/1ps
module indirect_load_addressing
  import indirect_load_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              op_valid_in,
  input  wire logic              op_relative_in,
  input  wire logic              op_ptr_sel_in,
  input  wire logic [1:0]        pointer_mode_field_in,
  input  wire logic [OFS_W-1:0]  op_offset_in,
  input  wire logic              ptr_wr_in,
  input  wire logic              ptr_wr_sel_in,
  input  wire logic [PTR_W-1:0]  ptr_wr_data_in,
  input  wire logic              virt_access_in,
  input  wire logic              virt_sel_in,
  input  wire logic [DATA_W-1:0] mem_rdata_in,
  output logic                   busy_out,
  output logic                   mem_rd_out,
  output logic [PTR_W-1:0]       mem_addr_out,
  output logic [DATA_W-1:0]      working_reg_out,
  output logic                   w_load_out,
  output logic                   zero_flag_out,
  output logic                   zero_we_out,
  output logic [PTR_W-1:0]       file_select_pointer0_out,
  output logic [PTR_W-1:0]       file_select_pointer1_out,
  output logic [PTR_W-1:0]       virt_addr_out
);
  exec_state_t       state_r, state_nxt;
  logic [PTR_W-1:0]  ptr_r [2];
  logic [PTR_W-1:0]  ptr_nxt [2];
  logic [PTR_W-1:0]  addr_r, addr_nxt, virt_r, virt_nxt;
  logic [PTR_W-1:0]  wb_r, wb_nxt;
  logic              sel_r, sel_nxt, rd_r, rd_nxt, wl_r, wl_nxt;
  logic [DATA_W-1:0] w_r, w_nxt;
  logic              z_r, z_nxt;
  logic              busy_r, busy_nxt;

  // 16-bit add that wraps inside the pointer range
  function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p,
                                               input logic [PTR_W-1:0] d);
    ptr_add = PTR_W'(p + d); // see (RL6)
  endfunction

  always_comb begin
    logic [PTR_W-1:0] p;
    logic [PTR_W-1:0] ofs;
    p = ptr_r[op_ptr_sel_in];
    ofs = {{(PTR_W-OFS_W){op_offset_in[OFS_W-1]}}, op_offset_in};
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    addr_nxt = addr_r;
    wb_nxt = wb_r;
    sel_nxt = sel_r;
    rd_nxt = 1'b0;
    wl_nxt = 1'b0;
    w_nxt = w_r;
    z_nxt = z_r;
    virt_nxt = ptr_r[virt_sel_in]; // see (RL4) (RL5)
    case (state_r)
      ST_IDLE: begin
        if (op_valid_in) begin
          sel_nxt = op_ptr_sel_in;
          rd_nxt = 1'b1;
          state_nxt = ST_READ;
          if (op_relative_in) begin
            addr_nxt = ptr_add(p, ofs); // see (RL3)
            wb_nxt = p;
          end else begin
            case (pointer_mode_field_in) // see (RL2)
              MODE_PRE_INC: begin
                addr_nxt = ptr_add(p, PTR_ONE);
                wb_nxt = ptr_add(p, PTR_ONE);
              end
              MODE_PRE_DEC: begin
                addr_nxt = ptr_add(p, ~PTR_RESET);
                wb_nxt = ptr_add(p, ~PTR_RESET);
              end
              MODE_POST_INC: begin
                addr_nxt = p;
                wb_nxt = ptr_add(p, PTR_ONE);
              end
              default: begin
                addr_nxt = p;
                wb_nxt = ptr_add(p, ~PTR_RESET);
              end
            endcase
          end
        end else if (ptr_wr_in) begin
          ptr_nxt[ptr_wr_sel_in] = ptr_wr_data_in;
        end
      end
      ST_READ: begin
        state_nxt = ST_WRITE;
      end
      default: begin
        w_nxt = mem_rdata_in; // see (RL1)
        wl_nxt = 1'b1;
        z_nxt = (mem_rdata_in == DATA_ZERO); // see (RL7)
        ptr_nxt[sel_r] = wb_r; // see (RL3)
        state_nxt = ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      ptr_r[0] <= PTR_RESET;
      ptr_r[1] <= PTR_RESET;
      addr_r <= PTR_RESET;
      wb_r <= PTR_RESET;
      virt_r <= PTR_RESET;
      sel_r <= 1'b0;
      rd_r <= 1'b0;
      wl_r <= 1'b0;
      w_r <= DATA_ZERO;
      z_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      addr_r <= addr_nxt;
      wb_r <= wb_nxt;
      virt_r <= virt_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      wl_r <= wl_nxt;
      w_r <= w_nxt;
      z_r <= z_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy_out = busy_r;
  assign mem_rd_out = rd_r;
  assign mem_addr_out = addr_r;
  assign working_reg_out = w_r;
  assign w_load_out = wl_r;
  assign zero_flag_out = z_r;
  assign zero_we_out = wl_r;
  assign file_select_pointer0_out = ptr_r[0];
  assign file_select_pointer1_out = ptr_r[1];
  assign virt_addr_out = virt_r;

  // checks on the load sequence
  a_load_data: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL1)
    state_r == ST_WRITE |=> w_r == $past(mem_rdata_in) && wl_r)
    else $error("working register not loaded");
  a_pre_inc_addr: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL2)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && pointer_mode_field_in == MODE_PRE_INC
    |=> addr_r == PTR_W'($past(ptr_r[op_ptr_sel_in]) + 16'h0001))
    else $error("pre increment address wrong");
  a_pre_dec_addr: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL2)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && pointer_mode_field_in == MODE_PRE_DEC
    |=> addr_r == PTR_W'($past(ptr_r[op_ptr_sel_in]) - 16'h0001))
    else $error("pre decrement address wrong");
  a_pre_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && (pointer_mode_field_in == MODE_PRE_INC || pointer_mode_field_in == MODE_PRE_DEC)
    |=> ##2 ptr_r[sel_r] == addr_r)
    else $error("pre mode writeback wrong");
  a_post_dec_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && pointer_mode_field_in == MODE_POST_DEC
    |=> addr_r == $past(ptr_r[op_ptr_sel_in]) ##2
        ptr_r[sel_r] == PTR_W'(addr_r - 16'h0001))
    else $error("post decrement writeback wrong");
  a_post_inc_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && pointer_mode_field_in == MODE_POST_INC
    |=> addr_r == $past(ptr_r[op_ptr_sel_in]) ##2
        ptr_r[sel_r] == PTR_W'(addr_r + 16'h0001))
    else $error("post increment writeback wrong");
  a_rel_keep: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_IDLE && op_valid_in && op_relative_in
    |=> ##2 $stable(ptr_r[sel_r]))
    else $error("relative mode changed pointer");
  a_rel_addr: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_IDLE && op_valid_in && op_relative_in
    |=> addr_r == PTR_W'($past(ptr_r[op_ptr_sel_in])
                         + PTR_W'($signed($past(op_offset_in)))))
    else $error("relative address wrong");
  a_virt_redirect: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL4)
    1'b1 |=> virt_r == $past(ptr_r[virt_sel_in]))
    else $error("virtual access address wrong");
  a_wrap_top: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL6)
    state_r == ST_IDLE && op_valid_in && !op_relative_in
      && pointer_mode_field_in == MODE_PRE_INC && ptr_r[op_ptr_sel_in] == 16'hffff
    |=> addr_r == 16'h0000)
    else $error("pointer did not wrap");
  a_zero_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL7)
    wl_r |-> z_r == (w_r == DATA_ZERO))
    else $error("zero flag mismatch");
  a_read_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL1)
    rd_r |=> !rd_r ##1 wl_r)
    else $error("read sequence wrong");
  a_ptr_refuse: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL3)
    state_r == ST_READ && ptr_wr_in |=> $stable(ptr_r[0]) && $stable(ptr_r[1]))
    else $error("pointer written while busy");
  a_op_refuse: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL1)
    state_r == ST_WRITE && op_valid_in |=> !rd_r && !busy_r)
    else $error("load started while busy");
  a_w_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL7)
    state_r != ST_WRITE |=> $stable(z_r) && $stable(w_r))
    else $error("working register or flag changed");
  a_load_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL1)
    wl_r |=> !wl_r)
    else $error("load strobe too long");
  a_busy_span: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see (RL1)
    rd_r |-> busy_r)
    else $error("read outside busy");

  // main scenarios
  c_pre_dec: cover property (@(posedge clk_in)
    op_valid_in && !busy_out && pointer_mode_field_in == MODE_PRE_DEC);
  c_post_dec: cover property (@(posedge clk_in)
    op_valid_in && !busy_out && pointer_mode_field_in == MODE_POST_DEC);
  c_relative: cover property (@(posedge clk_in) op_valid_in && !busy_out && op_relative_in);
  c_zero_load: cover property (@(posedge clk_in) wl_r && z_r);
endmodule

// file: tb/mem_model.sv
// data memory model answering indirect reads
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk_in,
  input  wire logic        mem_rd_in,
  input  wire logic [15:0] mem_addr_in,
  output logic      [7:0]  mem_rdata_out
);
  initial mem_rdata_out = 8'h5a;
  // byte is a fold of the address, else a toggling pattern
  always @(posedge clk_in) begin
    if (mem_rd_in)
      mem_rdata_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8];
    else
      mem_rdata_out <= ~mem_rdata_out;
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the indirect load block
`timescale 1ns/1ps
module testbench;
  import indirect_load_pkg::*;
  logic        clk_in = 0, reset_n_in = 0, opv = 0, rel = 0, sel = 0, pw = 0, ps = 0;
  logic [1:0]  mode = 0;
  logic [5:0]  ofs = 0;
  logic        vs = 0, r;
  logic [15:0] pd = 0, ea, np, v;
  logic [15:0] p [2];
  logic [7:0]  rd, w, eb;
  logic [7:0]  exp_q [$];
  logic        busy, mrd, wld, z, zwe;
  logic [15:0] ma, p0, p1, va;
  int          miscompares = 0, compares = 0, cyc = 0, k, m;
  always #20 clk_in = ~clk_in;
  mem_model u_mem (.clk_in(clk_in), .mem_rd_in(mrd), .mem_addr_in(ma), .mem_rdata_out(rd));
  indirect_load_addressing u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .op_valid_in(opv), .op_relative_in(rel), .op_ptr_sel_in(sel),
    .pointer_mode_field_in(mode), .op_offset_in(ofs), .ptr_wr_in(pw),
    .ptr_wr_sel_in(ps), .ptr_wr_data_in(pd), .virt_access_in(1'b0), .virt_sel_in(vs),
    .mem_rdata_in(rd), .busy_out(busy), .mem_rd_out(mrd), .mem_addr_out(ma),
    .working_reg_out(w), .w_load_out(wld), .zero_flag_out(z), .zero_we_out(zwe),
    .file_select_pointer0_out(p0), .file_select_pointer1_out(p1), .virt_addr_out(va));
  task automatic chk_addr(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(58));
    p[0] = 0;
    p[1] = 0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1;
    for (int i = 0; i < 60; i++) begin
      v = i == 0 ? 16'hffff : i == 1 ? 16'h0000 : i == 2 ? 16'h0101 : 16'($urandom);
      m = i < 4 ? i : $urandom % 4;
      k = $urandom % 64;
      if (k > 31)
        k -= 64;
      r = i >= 4 && $urandom % 4 == 0;
      @(posedge clk_in);
      ps <= 1'(i);
      sel <= 1'(i);
      vs <= 1'($urandom);
      pw <= 1;
      pd <= v;
      p[i % 2] = v;
      #1 chk_bit("w_load_end", 1'b0, wld);
      @(posedge clk_in);
      pw <= 0;
      @(posedge clk_in);
      opv <= 1;
      rel <= r;
      mode <= 2'(m);
      ofs <= 6'(k);
      #1 chk_addr("virt_addr", p[vs], va);
      @(posedge clk_in);
      opv <= 0;
      pw <= 1;
      ps <= 1'($urandom);
      pd <= ~v;
      if (r)
        ea = p[sel] + 16'(k);
      else if (m < 2)
        ea = m == 0 ? p[sel] + 16'h0001 : p[sel] - 16'h0001;
      else
        ea = p[sel];
      np = r ? p[sel] : m[0] ? p[sel] - 16'h0001 : p[sel] + 16'h0001;
      p[sel] = np;
      exp_q.push_back(ea[7:0] ^ ea[15:8]);
      #1 chk_bit("mem_rd", 1'b1, mrd);
      chk_addr("mem_addr", ea, ma);
      chk_bit("busy", 1'b1, busy);
      @(posedge clk_in);
      pw <= 0;
      opv <= 1;
      #1 chk_bit("mem_rd_end", 1'b0, mrd);
      chk_bit("busy_mid", 1'b1, busy);
      @(posedge clk_in);
      opv <= 0;
      #1 eb = exp_q.pop_front();
      chk_byte("working_reg", eb, w);
      chk_bit("w_load", 1'b1, wld);
      chk_bit("zero_flag", eb == 8'h00, z);
      chk_bit("zero_we", 1'b1, zwe);
      chk_bit("busy_end", 1'b0, busy);
      chk_addr("pointer0", p[0], p0);
      chk_addr("pointer1", p[1], p1);
    end
    finish_test();
  end
endmodule
